// >>> logic/udsm_pkg.sv
// Constants for the USB device state and interrupt mask register block.
// Assumes a 32-bit APB with byte addresses and a 100 MHz pclk.
package udsm_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FIDX_W = 11;
  localparam int FUNCTION_ADDRESS_W = 7;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_FRAME = 12'h000;
  localparam logic [11:0] OFS_STATE = 12'h004;
  localparam logic [11:0] OFS_FADDR = 12'h008;
  localparam logic [11:0] OFS_IRQ_SET = 12'h010;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h014;
  localparam logic [11:0] OFS_IRQ_VIEW = 12'h018;
  localparam logic [11:0] OFS_FRAME_HI = 12'h0F0;
  localparam logic [11:0] OFS_FRAME_LO = 12'h0F4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_FRAME_BAD = 16;
  localparam int POS_FRAME_GOOD = 17;
  localparam int POS_ADDR_STATE = 0;
  localparam int POS_CONFIGURED = 1;
  localparam int POS_FUNC_EN = 8;
  localparam int POS_BYTE_GOOD = 4;
  localparam int POS_BYTE_BAD = 3;
  localparam int POS_BUS_RESET = 12;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic FUNC_EN_RST = 1'b1;
  localparam logic [6:0] FUNCTION_ADDRESS_RST = 7'h00;
  localparam logic [31:0] MASK_RST = 32'h0000_1200;
  localparam logic [31:0] MASK_WRITABLE = 32'h0000_2B3F;
  localparam logic [31:0] MASK_ALWAYS_ON = 32'h0000_1000;

  // ****************************************************************
  // Bus slave phases
  // ****************************************************************
  typedef enum logic [0:0] {
    UDSM_IDLE = 1'b0,
    UDSM_ANSWER = 1'b1
  } udsm_phase_t;

endpackage

// >>> logic/udsm_mask_cell.sv
// One interrupt mask bit with set, clear and restore inputs.
// Assumes set and clear come from separate one-cycle write strobes.
module udsm_mask_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  input wire logic restore,
  output logic q
);

  // Restore wins, then enable, then disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VAL;
    end else if (ce) begin
      if (restore) begin
        q <= RESET_VAL;
      end else if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule // udsm_mask_cell

// >>> logic/udsm_frame_track.sv
// Start-of-frame tracker: frame index, good and bad flags, start pulse.
// Assumes token strobes are one-cycle pulses synchronous to pclk.
module udsm_frame_track
  import udsm_pkg::*;
#(
  parameter int IDX_W = FIDX_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic frame_token_id,
  input wire logic frame_token_end,
  input wire logic frame_token_error,
  input wire logic [IDX_W-1:0] frame_index_in,
  output logic [IDX_W-1:0] frame_index,
  output logic frame_good_flag,
  output logic frame_bad_flag,
  output logic frame_start_irq
);

  // Index and flags load at end of packet, flags drop at packet id
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_index <= '0;
      frame_good_flag <= 1'b0;
      frame_bad_flag <= 1'b0;
      frame_start_irq <= 1'b0;
    end else if (ce) begin
      frame_start_irq <= frame_token_id;
      if (frame_token_end) begin
        frame_index <= frame_index_in;
        frame_good_flag <= !frame_token_error;
        frame_bad_flag <= frame_token_error;
      end else if (frame_token_id) begin
        frame_good_flag <= 1'b0;
        frame_bad_flag <= 1'b0;
      end
    end
  end

endmodule // udsm_frame_track

// >>> logic/udsm_regs.sv
// USB device state and interrupt mask registers on an APB slave.
// Assumes frame token strobes from the bus engine, status flags from
// the interrupt status register, and one pclk domain.
//
// What this block does
// - Capture 11-bit frame index at token end
// - Bad flag set at end, cleared at id
// - Good flag set at end, cleared at id
// - Frame start status raised at token id
// - Byte views place good/bad at bits 4/3
// - Address state set by one, only reset clears
// - Configured bit writes both ways, reads back
// - Seven-bit function address, zero after reset
// - Function enable gates endpoint data traffic
// - Enable register writes set mask bits
// - Disable register writes clear mask bits
// - Mask view reports endpoint enables
// - Mask view reports suspend and resume enables
// - Bus reset mask bit always reads one
// - Bus reset end restores mask, endpoint control
//
// Added by the designer: the APB interface to the registers and the register addresses.
module udsm_regs
  import udsm_pkg::*;
#(
  parameter bit BYTE_IF = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [udsm_pkg::ADDR_W-1:0] paddr,
  input wire logic [udsm_pkg::DATA_W-1:0] pwdata,
  output logic [udsm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_token_id,
  input wire logic frame_token_end,
  input wire logic frame_token_error,
  input wire logic [udsm_pkg::FIDX_W-1:0] frame_index_in,
  input wire logic bus_reset_done_irq,
  input wire logic [udsm_pkg::DATA_W-1:0] irq_status,
  output logic frame_start_irq,
  output logic endpoint_ctrl_restore,
  output logic address_state,
  output logic configured,
  output logic [udsm_pkg::FUNCTION_ADDRESS_W-1:0] function_address,
  output logic function_enable,
  output logic irq
);
  import udsm_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  udsm_phase_t phase;
  udsm_phase_t next_phase;
  logic [FIDX_W-1:0] frame_index;
  logic frame_good_flag;
  logic frame_bad_flag;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] mask_view;
  logic [DATA_W-1:0] next_prdata;
  logic [DATA_W-1:0] frame_word;
  logic [DATA_W-1:0] state_word;
  logic [DATA_W-1:0] faddr_word;
  logic [DATA_W-1:0] frame_hi_word;
  logic [DATA_W-1:0] frame_lo_word;
  logic setup;
  logic write_go;
  logic wr_state;
  logic wr_faddr;
  logic wr_set;
  logic wr_clr;
  logic hit_frame;
  logic hit_state;
  logic hit_faddr;
  logic hit_set;
  logic hit_clr;
  logic hit_view;
  logic hit_byte;
  logic hit_hi;
  logic hit_lo;
  logic mapped;

  // ****************************************************************
  // Frame tracking
  // ****************************************************************

  // Frame index, flags and start pulse
  udsm_frame_track #(
    .IDX_W(FIDX_W)
  ) u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .frame_token_id(frame_token_id),
    .frame_token_end(frame_token_end),
    .frame_token_error(frame_token_error),
    .frame_index_in(frame_index_in),
    .frame_index(frame_index),
    .frame_good_flag(frame_good_flag),
    .frame_bad_flag(frame_bad_flag),
    .frame_start_irq(frame_start_irq)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Phase and strobe decode
  assign setup = psel && !penable && (phase == UDSM_IDLE);
  assign write_go = psel && penable && pready && pwrite;
  assign hit_frame = (paddr == OFS_FRAME);
  assign hit_state = (paddr == OFS_STATE);
  assign hit_faddr = (paddr == OFS_FADDR);
  assign hit_set = (paddr == OFS_IRQ_SET);
  assign hit_clr = (paddr == OFS_IRQ_CLR);
  assign hit_view = (paddr == OFS_IRQ_VIEW);
  assign hit_hi = BYTE_IF && (paddr == OFS_FRAME_HI);
  assign hit_lo = BYTE_IF && (paddr == OFS_FRAME_LO);
  assign hit_byte = hit_hi || hit_lo;
  assign mapped = hit_frame || hit_state || hit_faddr || hit_set ||
    hit_clr || hit_view || hit_byte;

  // Write strobes, one cycle at the completing edge
  assign wr_state = write_go && hit_state;
  assign wr_faddr = write_go && hit_faddr;
  assign wr_set = write_go && hit_set;
  assign wr_clr = write_go && hit_clr;

  // ****************************************************************
  // Read words
  // ****************************************************************

  // Full-width frame word, reserved bits zero
  always_comb begin
    frame_word = '0;
    frame_word[FIDX_W-1:0] = frame_index;
    frame_word[POS_FRAME_BAD] = frame_bad_flag;
    frame_word[POS_FRAME_GOOD] = frame_good_flag;
  end

  // High byte view: good flag over the top index bits
  always_comb begin
    frame_hi_word = '0;
    frame_hi_word[FIDX_W-9:0] = frame_index[FIDX_W-1:8];
    frame_hi_word[POS_BYTE_GOOD] = frame_good_flag;
  end

  // Low byte view: bad flag only
  always_comb begin
    frame_lo_word = '0;
    frame_lo_word[POS_BYTE_BAD] = frame_bad_flag;
  end

  // Device state word
  always_comb begin
    state_word = '0;
    state_word[POS_ADDR_STATE] = address_state;
    state_word[POS_CONFIGURED] = configured;
  end

  // Function address word
  always_comb begin
    faddr_word = '0;
    faddr_word[FUNCTION_ADDRESS_W-1:0] = function_address;
    faddr_word[POS_FUNC_EN] = function_enable;
  end

  // Mask view with the bus reset source forced on
  always_comb begin
    mask_view = mask_q & MASK_WRITABLE;
    mask_view[POS_BUS_RESET] = 1'b1;
  end

  // Read data mux; write-only offsets read zero
  always_comb begin
    next_prdata = '0;
    if (!pwrite) begin
      if (hit_frame) begin
        next_prdata = frame_word;
      end else if (hit_state) begin
        next_prdata = state_word;
      end else if (hit_faddr) begin
        next_prdata = faddr_word;
      end else if (hit_view) begin
        next_prdata = mask_view;
      end else if (hit_hi) begin
        next_prdata = frame_hi_word;
      end else if (hit_lo) begin
        next_prdata = frame_lo_word;
      end
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // One wait-free access phase after each setup
  always_comb begin
    case (phase)
      UDSM_IDLE: next_phase = setup ? UDSM_ANSWER : UDSM_IDLE;
      UDSM_ANSWER: next_phase = UDSM_IDLE;
      default: next_phase = UDSM_IDLE;
    endcase
  end

  // Registered answer: ready, error and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= UDSM_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      phase <= next_phase;
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  // ****************************************************************
  // Device state and function address
  // ****************************************************************

  // Address state sticks until reset; configured follows writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_state <= 1'b0;
      configured <= 1'b0;
    end else if (ce) begin
      if (wr_state && pwdata[POS_ADDR_STATE]) begin
        address_state <= 1'b1;
      end
      if (wr_state) begin
        configured <= pwdata[POS_CONFIGURED];
      end
    end
  end

  // Function address and function enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_address <= FUNCTION_ADDRESS_RST;
      function_enable <= FUNC_EN_RST;
    end else if (ce) begin
      if (wr_faddr) begin
        function_address <= pwdata[FUNCTION_ADDRESS_W-1:0];
        function_enable <= pwdata[POS_FUNC_EN];
      end
    end
  end

  // ****************************************************************
  // Interrupt mask
  // ****************************************************************

  // One cell per writable mask bit; others stay zero
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_mask
      if (MASK_WRITABLE[gi]) begin : g_cell
        udsm_mask_cell #(
          .RESET_VAL(MASK_RST[gi])
        ) u_cell (
          .pclk(pclk),
          .presetn(presetn),
          .ce(ce),
          .set(wr_set && pwdata[gi]),
          .clr(wr_clr && pwdata[gi]),
          .restore(bus_reset_done_irq),
          .q(mask_q[gi])
        );
      end else begin : g_zero
        assign mask_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // Outputs to the rest of the port
  // ****************************************************************

  // Endpoint control restore pulse and interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_ctrl_restore <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      endpoint_ctrl_restore <= bus_reset_done_irq;
      irq <= |(irq_status & mask_view);
    end
  end

endmodule // udsm_regs

// >>> dv/udsm_host_model.sv
// Host side model: frame tokens and end of bus reset, one pclk domain.
// Assumes tasks are called just after a rising edge of pclk.
module udsm_host_model
  import udsm_pkg::*;
(
  input wire logic pclk,
  output logic frame_token_id,
  output logic frame_token_end,
  output logic frame_token_error,
  output logic [udsm_pkg::FIDX_W-1:0] frame_index_in,
  output logic bus_reset_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet lines at start
  initial begin
    frame_token_id = 1'b0;
    frame_token_end = 1'b0;
    frame_token_error = 1'b0;
    frame_index_in = '0;
    bus_reset_done_irq = 1'b0;
  end
  // Packet id strobe of a frame token
  task automatic frame_id();
    frame_token_id <= 1'b1;
    @(posedge pclk);
    frame_token_id <= 1'b0;
  endtask
  // End of packet after a gap; lines scrambled once released
  task automatic frame_end(input logic [10:0] i, input logic bad,
                           input int gap);
    repeat (gap) @(posedge pclk);
    frame_token_end <= 1'b1;
    frame_token_error <= bad;
    frame_index_in <= i;
    @(posedge pclk);
    frame_token_end <= 1'b0;
    frame_token_error <= ~bad;
    frame_index_in <= ~i;
  endtask
  // End of a bus reset
  task automatic bus_reset();
    bus_reset_done_irq <= 1'b1;
    @(posedge pclk);
    bus_reset_done_irq <= 1'b0;
  endtask
endmodule // udsm_host_model

// >>> dv/udsm_regs_sva.sv
// Checker for the device state and mask registers.
// Assumes it is bound to udsm_regs and sees its ports only.
module udsm_regs_sva
  import udsm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [udsm_pkg::ADDR_W-1:0] paddr,
  input wire logic [udsm_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic frame_token_id,
  input wire logic bus_reset_done_irq,
  input wire logic [udsm_pkg::DATA_W-1:0] irq_status,
  input wire logic frame_start_irq,
  input wire logic endpoint_ctrl_restore,
  input wire logic address_state,
  input wire logic configured,
  input wire logic function_enable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Answered read and write access phases
  wire logic rd_acc = psel && penable && pready && !pwrite;
  wire logic wr_acc = psel && penable && pready && pwrite;

  start_pulse_a: assert property (ce && frame_token_id |=> frame_start_irq)
    else $error("frame start pulse missing");
  start_cause_a: assert property (frame_start_irq |-> $past(frame_token_id))
    else $error("frame start pulse without token id");
  restore_pulse_a: assert property (
    ce && bus_reset_done_irq |=> endpoint_ctrl_restore)
    else $error("restore pulse missing");
  addr_sticky_a: assert property (address_state |=> address_state)
    else $error("address state left without reset");
  fen_write_a: assert property (
    !$stable(function_enable) |-> $past(wr_acc && paddr == OFS_FADDR))
    else $error("function enable changed without write");
  cfg_write_a: assert property (
    !$stable(configured) |-> $past(wr_acc && paddr == OFS_STATE))
    else $error("configured changed without write");
  frame_zero_a: assert property (rd_acc && paddr == OFS_FRAME |->
    prdata[31:18] == 14'h0 && prdata[15:11] == 5'h0)
    else $error("frame word reserved bits set");
  bit12_on_a: assert property (rd_acc && paddr == OFS_IRQ_VIEW |->
    prdata[12] && prdata[31:14] == 18'h0)
    else $error("mask view bit 12 or upper bits wrong");
  irq_on_a: assert property (
    ce && |(irq_status & MASK_ALWAYS_ON) |=> irq)
    else $error("unmaskable status gave no request");
  irq_off_a: assert property (ce && irq_status == 32'h0 |=> !irq)
    else $error("request without status");
endmodule // udsm_regs_sva

bind udsm_regs udsm_regs_sva udsm_regs_sva_i (.*);

// >>> dv/usb_device_state_and_irq_mask_test.sv
// Self-checking bench for udsm_regs over APB with a host model.
// Assumes the checker is bound through its own file.
module usb_device_state_and_irq_mask_test import udsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] irq_status = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, frame_start_irq, endpoint_ctrl_restore;
  logic address_state, configured, function_enable, irq;
  logic [FUNCTION_ADDRESS_W-1:0] function_address;
  logic frame_token_id, frame_token_end, frame_token_error;
  logic bus_reset_done_irq, pe;
  logic [FIDX_W-1:0] frame_index_in, idx, last;
  logic [31:0] seed = 32'h69B2;
  logic [31:0] r, m;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  udsm_regs udsm_regs_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_token_id(frame_token_id), .frame_token_end(frame_token_end),
    .frame_token_error(frame_token_error), .frame_index_in(frame_index_in),
    .bus_reset_done_irq(bus_reset_done_irq), .irq_status(irq_status),
    .frame_start_irq(frame_start_irq), .irq(irq),
    .endpoint_ctrl_restore(endpoint_ctrl_restore), .configured(configured),
    .address_state(address_state), .function_address(function_address),
    .function_enable(function_enable));
  udsm_host_model udsm_host_model_i (.pclk(pclk),
    .frame_token_id(frame_token_id), .frame_token_end(frame_token_end),
    .frame_token_error(frame_token_error), .frame_index_in(frame_index_in),
    .bus_reset_done_irq(bus_reset_done_irq));

  // Clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected frame word from index and outcome
  function automatic logic [31:0] frame_word(input logic [10:0] i,
                                             input logic bad, done);
    return {14'h0, done & ~bad, done & bad, 5'h0, i};
  endfunction
  // Expected mask after a set or clear write
  function automatic logic [31:0] mask_next(input logic [31:0] mk,
                                            input logic set,
                                            input logic [31:0] d);
    if (set) return mk | (d & MASK_WRITABLE) | MASK_ALWAYS_ON;
    return (mk & ~(d & MASK_WRITABLE)) | MASK_ALWAYS_ON;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    last = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_FRAME, 32'h0, "frame");
    rd(OFS_STATE, 32'h0, "state");
    rd(OFS_FADDR, 32'h0000_0100, "faddr");
    rd(OFS_IRQ_VIEW, MASK_RST, "mask");
    rd(OFS_IRQ_SET, 32'h0, "write only");
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, pe});
    chk("unmapped data", 32'h0, r);
    wr(OFS_FRAME, 32'hFFFF_FFFF);
    rd(OFS_FRAME, 32'h0, "read only");
    $display("reset and map done");
    // Mask set and clear, request output against random status
    m = MASK_RST;
    for (int k = 0; k < 24; k++) begin
      r = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h7FFF_FFFF : xs();
      irq_status <= xs() & {32{k[0]}};
      wr(r[31] ? OFS_IRQ_SET : OFS_IRQ_CLR, r);
      m = mask_next(m, r[31], r);
      rd(OFS_IRQ_VIEW, m, "mask view");
      chk("irq", {31'h0, |(irq_status & m)}, {31'h0, irq});
    end
    $display("mask done");
    // Frames, good and bad, fast and slow
    for (int k = 0; k < 4; k++) begin
      r = xs();
      idx = (k == 3) ? 11'h7FF : r[10:0];
      udsm_host_model_i.frame_id();
      rd(OFS_FRAME, frame_word(last, 1'b0, 1'b0), "flags cleared");
      udsm_host_model_i.frame_end(idx, k[0], k);
      rd(OFS_FRAME, frame_word(idx, k[0], 1'b1), "frame");
      apb(1'b0, OFS_FRAME_HI, 32'h0, r);
      chk("high good", {27'h0, ~k[0], 1'b0, idx[10:8]}, r);
      apb(1'b0, OFS_FRAME_LO, 32'h0, r);
      chk("low bad", {28'h0, k[0], 3'h0}, r);
      last = idx;
    end
    $display("frames done");
    // Device state sequence
    r = xs();
    wr(OFS_FADDR, {23'h0, 1'b1, 1'b0, r[6:0]});
    rd(OFS_FADDR, {23'h0, 1'b1, 1'b0, r[6:0]}, "faddr");
    wr(OFS_STATE, 32'h0000_0001);
    rd(OFS_STATE, 32'h1, "address");
    wr(OFS_STATE, 32'hFFFF_FFFE);
    rd(OFS_STATE, 32'h3, "configured");
    chk("state pins", 32'h3, {30'h0, configured, address_state});
    wr(OFS_STATE, 32'h0);
    rd(OFS_STATE, 32'h1, "unconfigured");
    wr(OFS_FADDR, 32'h0000_007F);
    rd(OFS_FADDR, 32'h7F, "disabled");
    chk("enable pin", 32'h0, {31'h0, function_enable});
    chk("address pin", 32'h7F, {25'h0, function_address});
    // Bus reset restores the mask, not the device state
    wr(OFS_IRQ_SET, 32'hFFFF_FFFF);
    udsm_host_model_i.bus_reset();
    rd(OFS_IRQ_VIEW, MASK_RST, "mask restored");
    rd(OFS_STATE, 32'h1, "state kept");
    $display("state done");
    // Mid-run reset returns state, address and enable to defaults
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STATE, 32'h0, "state after reset");
    rd(OFS_FADDR, 32'h0000_0100, "faddr after reset");
    chk("address pin", 32'h0, {25'h0, function_address});
    $display("reset done");
    finish_test();
  end
endmodule // usb_device_state_and_irq_mask_test
